// ---- pot_register_i2c_transfer.sv ----
// i2c slave transfer logic of a digital potentiometer with register file
// assumes open-drain sda/scl resolved outside; scl/sda are async pins
`timescale 1ns/1ns
`default_nettype none
`include "pot_i2c_regs.svh"
module pot_register_i2c_transfer (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      wiper_pos,
  output logic            prog_busy
);
  pot_i2c_pkg::state_type st, next_st;
  logic [7:0] nv_mem [0:6];   // non-volatile store, index 0 is initial value
  logic       scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_byte, byte_in;
  logic       nv_commit;

  // synchronised pins and bus conditions
  assign scl_s    = st.pins.scl_sync[1];
  assign sda_s    = st.pins.sda_sync[1];
  assign scl_rise = scl_s & ~st.pins.scl_prev;
  assign scl_fall = ~scl_s & st.pins.scl_prev;
  assign start_c  = scl_s & st.pins.scl_prev & st.pins.sda_prev & ~sda_s;
  assign stop_c   = scl_s & st.pins.scl_prev & ~st.pins.sda_prev & sda_s;
  assign byte_in  = {st.shift[6:0], sda_s};

  // register address after auto-increment: the top register wraps to 00h
  function automatic logic [3:0] step_addr(input logic [3:0] a);
    step_addr = (a == `REG_ACCESS_SEL) ? `REG_WIPER : a + 4'h1;
  endfunction : step_addr

  // register read multiplexer
  always_comb begin
    rd_byte = `GP_RESET;
    case (st.addr)
      `REG_WIPER:      rd_byte = st.access_sel[`SELECT_BIT] ? st.wiper
                                 : nv_mem[0];
      `REG_DEVICE_ID:  rd_byte = `DEVICE_ID_VALUE;
      `REG_RESERVED:   rd_byte = `RESERVED_VALUE;
      `REG_ACCESS_SEL: rd_byte = st.access_sel;
      default:         rd_byte = (st.addr < `REG_RESERVED) ?
                                 nv_mem[st.addr[2:0]] : `RESERVED_VALUE;
    endcase
  end

  // main transfer engine
  always_comb begin
    next_st = st;
    nv_commit = 1'b0;
    next_st.pins.scl_sync = {st.pins.scl_sync[0], scl};
    next_st.pins.sda_sync = {st.pins.sda_sync[0], sda_in};
    next_st.pins.scl_prev = scl_s;
    next_st.pins.sda_prev = sda_s;
    if (st.prog_cnt != 23'h0) begin
      next_st.prog_cnt = st.prog_cnt - 23'h1;
    end
    if (stop_c) begin
      next_st.phase = pot_i2c_pkg::st_idle;
      next_st.sda_low = 1'b0;
      next_st.reg_given = 1'b0;
      if (st.nv_pend) begin
        nv_commit = 1'b1;
        next_st.nv_pend = 1'b0;
        next_st.prog_cnt = 23'(`PROG_CYCLES);
      end
    end else if (start_c) begin
      next_st.nv_pend = 1'b0;
      next_st.nv_seen = 1'b0;
      next_st.sda_low = 1'b0;
      next_st.byte_full = 1'b0;
      next_st.bitcnt = 3'h0;
      next_st.phase = (st.prog_cnt != 23'h0) ? pot_i2c_pkg::st_idle
                      : pot_i2c_pkg::st_dev;
    end else begin
      case (st.phase)
        pot_i2c_pkg::st_idle: next_st.sda_low = 1'b0;
        pot_i2c_pkg::st_dev, pot_i2c_pkg::st_reg,
        pot_i2c_pkg::st_wdata: begin
          if (scl_rise) begin
            next_st.shift = byte_in;
            next_st.bitcnt = st.bitcnt + 3'h1;
          end
          if (scl_rise && st.bitcnt == `BIT_LAST) begin
            next_st.byte_full = 1'b1;
            next_st.ack_ok = 1'b0;
            if (st.phase == pot_i2c_pkg::st_dev) begin
              if (byte_in == `SLAVE_ADDR_WR) begin
                next_st.ack_ok = 1'b1;
                next_st.rd_dir = 1'b0;
                next_st.reg_given = 1'b0;
              end else if (byte_in == `SLAVE_ADDR_RD) begin
                next_st.ack_ok = 1'b1;
                next_st.rd_dir = 1'b1;
                next_st.addr = st.reg_given ? st.addr
                               : step_addr(st.last_addr);
              end
            end else if (st.phase == pot_i2c_pkg::st_reg) begin
              next_st.ack_ok = (byte_in[7:4] == 4'h0) &&
                               (byte_in[3:0] != `REG_RESERVED) &&
                               (byte_in[3:0] <= `REG_ACCESS_SEL);
              next_st.reg_given = next_st.ack_ok;
              next_st.addr = byte_in[3:0];
              next_st.last_addr = byte_in[3:0];
            end else if (!st.nv_seen) begin
              next_st.ack_ok = 1'b1;
              next_st.last_addr = st.addr;
              next_st.addr = step_addr(st.addr);
              case (st.addr)
                `REG_ACCESS_SEL: begin
                  next_st.access_sel = {byte_in[`SELECT_BIT], 7'h00};
                  next_st.ack_ok = (byte_in[6:0] == 7'h00);
                end
                `REG_DEVICE_ID: next_st.ack_ok = 1'b1; // read only
                `REG_WIPER: begin
                  next_st.wiper = byte_in;
                  if (!st.access_sel[`SELECT_BIT]) begin
                    next_st.nv_seen = 1'b1;
                    next_st.nv_pend = 1'b1;
                    next_st.nv_addr = st.addr;
                    next_st.nv_data = byte_in;
                  end
                end
                default: begin
                  next_st.nv_seen = 1'b1;
                  next_st.nv_pend = 1'b1;
                  next_st.nv_addr = st.addr;
                  next_st.nv_data = byte_in;
                end
              endcase
            end
          end
          // ack slot opens on the fall after the eighth bit
          if (scl_fall && st.byte_full) begin
            next_st.byte_full = 1'b0;
            next_st.bitcnt = 3'h0;
            next_st.sda_low = st.ack_ok;
            if (!st.ack_ok) begin
              next_st.phase = pot_i2c_pkg::st_idle;
            end else if (st.phase == pot_i2c_pkg::st_dev) begin
              next_st.phase = pot_i2c_pkg::st_dack;
            end else begin
              next_st.phase = pot_i2c_pkg::st_wack;
            end
          end
        end
        pot_i2c_pkg::st_dack: begin
          if (scl_fall) begin
            next_st.bitcnt = 3'h0;
            if (st.rd_dir) begin
              next_st.phase = pot_i2c_pkg::st_rdata;
              next_st.shift = rd_byte;
              next_st.sda_low = ~rd_byte[7];
            end else begin
              next_st.phase = pot_i2c_pkg::st_reg;
              next_st.sda_low = 1'b0;
            end
          end
        end
        pot_i2c_pkg::st_wack: begin
          if (scl_fall) begin
            next_st.sda_low = 1'b0;
            next_st.bitcnt = 3'h0;
            next_st.phase = pot_i2c_pkg::st_wdata;
          end
        end
        pot_i2c_pkg::st_rdata: begin
          if (scl_fall) begin
            next_st.bitcnt = st.bitcnt + 3'h1;
            next_st.shift = {st.shift[6:0], 1'b1};
            next_st.sda_low = ~st.shift[6];
            if (st.bitcnt == `BIT_LAST) begin
              next_st.sda_low = 1'b0; // leave sda to the host ack
              next_st.last_addr = st.addr;
              next_st.phase = pot_i2c_pkg::st_rack;
            end
          end
        end
        pot_i2c_pkg::st_rack: begin
          if (scl_rise) begin
            next_st.ack_ok = ~sda_s;
            if (!sda_s) begin
              next_st.addr = step_addr(st.addr);
            end
          end
          if (scl_fall) begin
            next_st.bitcnt = 3'h0;
            if (st.ack_ok) begin
              next_st.phase = pot_i2c_pkg::st_rdata;
              next_st.shift = rd_byte;
              next_st.sda_low = ~rd_byte[7];
            end else begin
              next_st.phase = pot_i2c_pkg::st_idle;
            end
          end
        end
        default: next_st.phase = pot_i2c_pkg::st_idle;
      endcase
    end
  end

  // state register and non-volatile store
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.pins.scl_sync <= 2'b11;
      st.pins.sda_sync <= 2'b11;
      st.pins.scl_prev <= 1'b1;
      st.pins.sda_prev <= 1'b1;
      st.wiper <= `INIT_VALUE_RESET;
      st.access_sel <= `ACCESS_SEL_RESET;
      nv_mem[0] <= `INIT_VALUE_RESET;
      for (int i = 1; i < 7; i++) nv_mem[i] <= `GP_RESET;
    end else begin
      st <= next_st;
      if (nv_commit) begin
        nv_mem[st.nv_addr[2:0]] <= st.nv_data;
      end
    end
  end

  // open-drain sda: only ever pulled low
  assign sda_out   = 1'b0;
  assign sda_oe    = st.sda_low;
  assign wiper_pos = st.wiper;
  assign prog_busy = (st.prog_cnt != 23'h0);

  // the bus stays quiet while programming runs
  property p_busy_quiet;
    @(posedge clk_sys) disable iff (!nrst)
      prog_busy |-> !sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("sda driven while programming");

  // only the two own slave addresses reach the ack slot
  property p_addr_match;
    @(posedge clk_sys) disable iff (!nrst)
      (st.phase == pot_i2c_pkg::st_dack) |->
        (st.shift == `SLAVE_ADDR_WR || st.shift == `SLAVE_ADDR_RD);
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("ack given to a foreign slave address");

  // an acked register address is inside the map
  property p_reg_range;
    @(posedge clk_sys) disable iff (!nrst)
      (st.phase == pot_i2c_pkg::st_wack &&
       $past(st.phase) == pot_i2c_pkg::st_reg) |->
        (st.addr != `REG_RESERVED && st.addr <= `REG_ACCESS_SEL);
  endproperty
  a_reg_range: assert property (p_reg_range)
    else $error("ack given to a refused register address");

  // a repeated start drops a pending non-volatile byte
  property p_restart_drop;
    @(posedge clk_sys) disable iff (!nrst)
      (start_c && st.nv_pend) |=> !st.nv_pend;
  endproperty
  a_restart_drop: assert property (p_restart_drop)
    else $error("pending byte kept across a repeated start");

  // programming only ever starts from a stop
  property p_stop_commit;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(prog_busy) |-> $past(stop_c);
  endproperty
  a_stop_commit: assert property (p_stop_commit)
    else $error("programming started without a stop");

  // no byte is acked once a non-volatile byte came in
  property p_no_after_nv;
    @(posedge clk_sys) disable iff (!nrst)
      ($rose(st.byte_full) && st.phase == pot_i2c_pkg::st_wdata &&
       $past(st.nv_seen)) |-> !st.ack_ok;
  endproperty
  a_no_after_nv: assert property (p_no_after_nv)
    else $error("byte acked after a non-volatile byte");

  // a volatile-mode write to 00h never schedules programming
  property p_vol_no_store;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(st.nv_pend) |->
        (st.nv_addr != `REG_WIPER || !st.access_sel[`SELECT_BIT]);
  endproperty
  a_vol_no_store: assert property (p_vol_no_store)
    else $error("volatile write scheduled for programming");
endmodule : pot_register_i2c_transfer
`default_nettype wire

// ---- pot_i2c_regs.svh ----
// constants for the potentiometer i2c register transfer logic
// assumes inclusion by bare name from the design file
`ifndef POT_I2C_REGS_SVH
`define POT_I2C_REGS_SVH
`define SLAVE_ADDR_WR   8'h50
`define SLAVE_ADDR_RD   8'h51
`define REG_WIPER       4'h0
`define REG_DEVICE_ID   4'h1
`define REG_RESERVED    4'h7
`define REG_ACCESS_SEL  4'h8
`define SELECT_BIT      7
`define INIT_VALUE_RESET 8'h80
`define GP_RESET        8'h00
`define RESERVED_VALUE  8'hff
// identity value is arbitrary, chosen only to be recognisable
`define DEVICE_ID_VALUE 8'ha5
`define ACCESS_SEL_RESET 8'h00
`define PROG_TIME_NS    5000000
`define CLK_PERIOD_NS   10
`define PROG_CYCLES     ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_LAST        3'h7
`endif

// ---- pot_i2c_pkg.sv ----
// types for the potentiometer i2c register transfer logic
// assumes pot_i2c_regs.svh holds the numeric constants
package pot_i2c_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_dev   = 3'b001,
    st_dack  = 3'b011,
    st_reg   = 3'b010,
    st_wdata = 3'b110,
    st_wack  = 3'b111,
    st_rdata = 3'b101,
    st_rack  = 3'b100
  } phase_type;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;
  } pins_type;

  typedef struct packed {
    pins_type   pins;
    phase_type  phase;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic       ack_ok;
    logic       sda_low;
    logic [3:0] addr;
    logic [3:0] last_addr;
    logic       nv_seen;
    logic       nv_pend;
    logic [3:0] nv_addr;
    logic [7:0] nv_data;
    logic [7:0] wiper;
    logic [7:0] access_sel;
    logic [22:0] prog_cnt;
    logic       byte_full;  // eight bits in, ack slot pending
    logic       rd_dir;     // current header asked for a read
    logic       reg_given;  // register address supplied since stop or write header
  } state_type;
endpackage : pot_i2c_pkg

// ---- i2c_host_model.sv ----
// i2c bus master model for the potentiometer bench
// assumes the bench resolves sda from sda_drv, the device and a pull-up
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_drv
);
  logic got;
  // bus idles with both lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // one quarter of the 80 ns bus period per step
  task step(input logic c, input logic d);
    scl <= c;
    sda_drv <= d;
    repeat (2) @(posedge clk_sys);
  endtask : step
  // scl falls with data held, sda set, scl high, sample, last sda level
  task cyc(input logic a, input logic b, input logic c);
    step(1'b0, sda_drv);
    step(1'b0, a);
    step(1'b1, b);
    got = sda_line;
    step(1'b1, c);
  endtask : cyc
  // nine bits msb first; a high bit leaves sda to the device
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      cyc(tx[i], tx[i], tx[i]);
      rx[i] = got;
    end
  endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the potentiometer i2c transfer logic
// assumes the host model and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "pot_i2c_regs.svh"
module testbench;
  logic       clk_sys;
  logic       nrst;
  logic       sda_out;
  logic       sda_oe;
  logic       prog_busy;
  logic [7:0] wiper_pos;
  logic       scl;
  logic       sda_drv;
  wire logic  sda_line;
  logic [8:0] r;
  int         err_count = 0;
  int         compares = 0;
  int         cycles = 0;
  // open-drain sda with pull-up
  assign sda_line = sda_drv & (~sda_oe | sda_out);
  pot_register_i2c_transfer u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .wiper_pos(wiper_pos),
    .prog_busy(prog_busy));
  i2c_host_model u_host (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // cut a hang short
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test;
    end
  end
  task stop_test;
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // bus framing and byte helpers
  task st;
    u_host.cyc(1'b1, 1'b1, 1'b0);
  endtask : st
  task sp;
    u_host.cyc(1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk_sys);
  endtask : sp
  task wb(input logic [7:0] b, input logic a);
    u_host.xfer({b, 1'b1}, r);
    chk("ack", {7'h0, a}, {7'h0, r[0]});
  endtask : wb
  task rb(input logic a, input logic [7:0] e);
    u_host.xfer({8'hff, a}, r);
    chk("rdata", e, r[8:1]);
  endtask : rb
  task wreg(input logic [7:0] a, input logic [7:0] d);
    st;
    wb(8'h50, 1'b0);
    wb(a, 1'b0);
    wb(d, 1'b0);
    sp;
  endtask : wreg
  task rd_at(input logic [7:0] a);
    st;
    wb(8'h50, 1'b0);
    wb(a, 1'b0);
    st;
    wb(8'h51, 1'b0);
  endtask : rd_at
  // scenarios
  task t_reset;
    chk("wiper", `INIT_VALUE_RESET, wiper_pos);
    chk("busy", 8'h00, {7'h0, prog_busy});
  endtask : t_reset
  task t_volatile;
    wreg(8'h08, 8'h80);
    wreg(8'h00, 8'h3c);
    chk("wiper", 8'h3c, wiper_pos);
    chk("busy", 8'h00, {7'h0, prog_busy});
  endtask : t_volatile
  task t_addrless;
    st;
    wb(8'h51, 1'b0);
    rb(1'b0, `DEVICE_ID_VALUE);
    rb(1'b1, `GP_RESET);
    sp;
  endtask : t_addrless
  task t_read;
    rd_at(8'h06);
    rb(1'b0, `GP_RESET);
    rb(1'b0, `RESERVED_VALUE);
    rb(1'b1, 8'h80);
    sp;
  endtask : t_read
  task t_nacks;
    logic [7:0] dev[2];
    logic [7:0] badr[3];
    dev = '{8'h52, 8'h71};
    badr = '{8'h07, 8'h09, 8'h0f};
    foreach (dev[i]) begin
      st;
      wb(dev[i], 1'b1);
      sp;
    end
    foreach (badr[i]) begin
      st;
      wb(8'h50, 1'b0);
      wb(badr[i], 1'b1);
      sp;
    end
  endtask : t_nacks
  // non-volatile byte followed by a repeated start instead of a stop
  task t_no_stop;
    wreg(8'h08, 8'h00);
    st;
    wb(8'h50, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h55, 1'b0);
    rd_at(8'h00);
    rb(1'b1, `INIT_VALUE_RESET);
    sp;
    chk("busy", 8'h00, {7'h0, prog_busy});
  endtask : t_no_stop
  // multi-write from 08h running past the non-volatile byte
  task t_multi;
    st;
    wb(8'h50, 1'b0);
    wb(8'h08, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'h5a, 1'b0);
    wb(8'h33, 1'b1);
    sp;
    chk("wiper", 8'h5a, wiper_pos);
    chk("busy", 8'h01, {7'h0, prog_busy});
    st;
    wb(8'h50, 1'b1);
    sp;
  endtask : t_multi
  // reset, then the scenarios in order
  initial begin
    nrst = 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset;
    t_volatile;
    t_addrless;
    t_read;
    t_nacks;
    t_no_stop;
    t_multi;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
